//--- pfcr_top.sv
// Parallel flash configuration reader: power-on delay, flash set-up and
// synchronous burst fetch of the bitstream into a word FIFO.
// Assumes a 50 MHz sys_clk, a synchronous reset and pin-level pads outside.
//
// What this block does
// - Fetch configuration words by continuous synchronous burst read on the config clock.
// - Config clock comes from internal clock and never exceeds 40 MHz.
// - Drive a 24-bit word address onto flash lines one to twenty-four.
// - One shared 16-bit bidirectional data bus carries reads and writes.
// - Drive flash clock and active-low reset, chip, output, address and write enables.
// - Flash ready/busy output is ignored entirely.
// - Flash starts in asynchronous reads; writes are asynchronous; sync reads after setup.
// - Address-valid low loads an address; write-enable low writes a word.
// - Up to 256 Mbit addressed directly; larger parts need external high lines.
// - Power-on delay chosen by mode pins; fast is over 3 ms, under 9 ms.
// - Standard power-on delay is over 50 ms and under 200 ms.
// - In power-on reset: logic held, status and done low, user I/O tri-stated.
// - After power-on reset user I/O stays tri-stated with weak pull-ups on.
// - After power-on reset release status, enter configuration, start reading flash.
// - After done goes high run 3185 init cycles, then enter user mode.
`timescale 1ns/1ps
`include "pfcr_regs.svh"

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module pfcr_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Fill side
    input  wire logic [W-1:0]           in_data,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    // Drain side
    output logic [W-1:0]                out_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    // Fill level
    output logic [$clog2(D+1)-1:0]      level
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    wire [AW-1:0] wp_inc = (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
    wire [AW-1:0] rp_inc = (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;

    assign in_ready  = (cnt_ff != CW'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rp_ff];
    assign level     = cnt_ff;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= push ? wp_inc : wp_ff;
            rp_ff  <= pop ? rp_inc : rp_ff;
            cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
        end
    end
endmodule : pfcr_fifo

// ----------------------------------------------------------------
// Configuration reader
// ----------------------------------------------------------------
module pfcr_top #(
    parameter int          ADDR_W          = 24,
    parameter int          DATA_W          = 16,
    parameter int          FIFO_DEPTH      = 4,
    parameter int unsigned POR_FAST_CYC    = `PFCR_POR_FAST_CYC,
    parameter int unsigned POR_STD_CYC     = `PFCR_POR_STD_CYC,
    parameter int unsigned INIT_CYC        = `PFCR_INIT_CYC,
    parameter int unsigned BITSTREAM_WORDS = 1024,
    parameter logic [23:0] START_ADDR      = 24'h000000,
    parameter logic [23:0] RCR_ADDR        = 24'h000000
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Mode straps
    input  wire logic [3:0]        scheme_select_pins,
    // Open-drain status and done pins
    output logic                   config_status_n_o,
    output logic                   config_status_n_oe,
    input  wire logic              config_complete_i,
    output logic                   config_complete_o,
    output logic                   config_complete_oe,
    // User I/O control
    output logic                   user_io_oe,
    output logic                   weak_pullup_en,
    output logic                   user_mode,
    // Flash controls
    output logic                   config_clk_out,
    output logic                   flash_hard_reset_n,
    output logic                   flash_chip_en_n,
    output logic                   flash_out_en_n,
    output logic                   flash_addr_valid_n,
    output logic                   flash_write_en_n,
    output logic [ADDR_W-1:0]      flash_word_addr,
    // Flash data and wait
    input  wire logic [DATA_W-1:0] flash_data_i,
    output logic [DATA_W-1:0]      flash_data_o,
    output logic                   flash_data_oe,
    input  wire logic              flash_wait,
    // Configuration word stream
    output logic [DATA_W-1:0]      cfg_word_data,
    output logic                   cfg_word_valid,
    input  wire logic              cfg_word_ready
);
    localparam int          SW   = DATA_W + 6;
    localparam int          CW   = $clog2(FIFO_DEPTH + 1);
    localparam int unsigned HALF = `PFCR_CFG_HALF_CYC;
    localparam int unsigned WP   = `PFCR_WR_PHASE_CYC;

    pfcr_pkg::pfcr_state_t st_ff;
    pfcr_pkg::pfcr_state_t nxt_st;

    logic [SW-1:0]     s1_ff;
    logic [SW-1:0]     s2_ff;
    logic [31:0]       cnt_ff;
    logic [7:0]        hc_ff;
    logic              clk_ff;
    logic              rd1_ff;
    logic              rd2_ff;
    logic              rd3_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [31:0]       words_ff;
    logic              fifo_rdy;
    logic [CW-1:0]     fifo_lvl;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Ready/busy pin of the flash has no input here
    wire [SW-1:0] pin_raw = {scheme_select_pins, config_complete_i, flash_wait, flash_data_i};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
        end
    end

    wire [3:0]        scheme_select_pins_s = s2_ff[SW-1 -: 4];
    wire              done_s = s2_ff[DATA_W + 1];
    wire              wait_s = s2_ff[DATA_W];
    wire [DATA_W-1:0] data_s = s2_ff[DATA_W-1:0];

    // ----------------------------------------------------------------
    // State decode
    // ----------------------------------------------------------------
    wire in_por   = (st_ff == pfcr_pkg::pfcr_st_por);
    wire in_wrset = (st_ff == pfcr_pkg::pfcr_st_wrset);
    wire in_wrcnf = (st_ff == pfcr_pkg::pfcr_st_wrcnf);
    wire in_baddr = (st_ff == pfcr_pkg::pfcr_st_baddr);
    wire in_bdata = (st_ff == pfcr_pkg::pfcr_st_bdata);
    wire in_dwait = (st_ff == pfcr_pkg::pfcr_st_dwait);
    wire in_init  = (st_ff == pfcr_pkg::pfcr_st_init);
    wire in_user  = (st_ff == pfcr_pkg::pfcr_st_user);
    wire in_wr    = in_wrset || in_wrcnf;

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    wire por_fast = (scheme_select_pins_s == `PFCR_SCHEME_SELECT_PINS_FAST_A) || (scheme_select_pins_s == `PFCR_SCHEME_SELECT_PINS_FAST_B);
    wire [31:0] por_lim = por_fast ? POR_FAST_CYC : POR_STD_CYC;
    wire por_end  = (cnt_ff >= por_lim - 32'd1);
    wire ph_end   = (cnt_ff == 2 * WP - 1);
    wire init_end = (cnt_ff == INIT_CYC - 32'd1);
    wire we_act   = in_wr && (cnt_ff >= 32'd1) && (cnt_ff <= WP);

    // ----------------------------------------------------------------
    // Configuration clock and burst capture
    // ----------------------------------------------------------------
    wire clk_run  = in_baddr || in_bdata;
    wire half_end = (hc_ff == 8'(HALF - 1));
    wire [CW:0] pend = (CW + 1)'(rd1_ff) + (CW + 1)'(rd2_ff) + (CW + 1)'(rd3_ff);
    // Hold the clock low while the FIFO could not take every word in flight
    wire room = fifo_rdy && (({1'b0, fifo_lvl} + pend) < (CW + 1)'(FIFO_DEPTH));
    wire rise = clk_run && half_end && !clk_ff && room;
    wire fall = half_end && clk_ff;
    // Pad sampled one cycle after the rise, then synchronised; taken only when wait is low
    wire cap = rd3_ff && in_bdata && !flash_out_en_n && !wait_s;
    wire last_cap = cap && (words_ff == BITSTREAM_WORDS - 32'd1);

    always_ff @(posedge sys_clk) begin
        if (rst || (!clk_run && !clk_ff) || (half_end && (clk_ff || rise))) begin
            hc_ff <= '0;
        end else if (!half_end) begin
            hc_ff <= hc_ff + 8'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_ff <= 1'b0;
            rd1_ff <= 1'b0;
            rd2_ff <= 1'b0;
            rd3_ff <= 1'b0;
        end else begin
            clk_ff <= rise ? 1'b1 : (fall ? 1'b0 : clk_ff);
            rd1_ff <= rise && in_bdata;
            rd2_ff <= rd1_ff;
            rd3_ff <= rd2_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || in_baddr) begin
            addr_ff  <= START_ADDR;
            words_ff <= '0;
        end else if (cap) begin
            addr_ff  <= addr_ff + 1'b1;
            words_ff <= words_ff + 32'd1;
        end
    end

    pfcr_fifo #(
        .W (DATA_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .rst       (rst),
        .in_data   (data_s),
        .in_valid  (cap),
        .in_ready  (fifo_rdy),
        .out_data  (cfg_word_data),
        .out_valid (cfg_word_valid),
        .out_ready (cfg_word_ready),
        .level     (fifo_lvl)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            pfcr_pkg::pfcr_st_por:   if (por_end) nxt_st = pfcr_pkg::pfcr_st_frst;
            pfcr_pkg::pfcr_st_frst:  if (ph_end) nxt_st = pfcr_pkg::pfcr_st_wrset;
            pfcr_pkg::pfcr_st_wrset: if (ph_end) nxt_st = pfcr_pkg::pfcr_st_wrcnf;
            pfcr_pkg::pfcr_st_wrcnf: if (ph_end) nxt_st = pfcr_pkg::pfcr_st_baddr;
            pfcr_pkg::pfcr_st_baddr: if (fall) nxt_st = pfcr_pkg::pfcr_st_bdata;
            pfcr_pkg::pfcr_st_bdata: if (last_cap) nxt_st = pfcr_pkg::pfcr_st_drain;
            pfcr_pkg::pfcr_st_drain: if (fifo_lvl == '0) nxt_st = pfcr_pkg::pfcr_st_dwait;
            pfcr_pkg::pfcr_st_dwait: if (done_s) nxt_st = pfcr_pkg::pfcr_st_init;
            pfcr_pkg::pfcr_st_init:  if (init_end) nxt_st = pfcr_pkg::pfcr_st_user;
            pfcr_pkg::pfcr_st_user:  nxt_st = pfcr_pkg::pfcr_st_user;
            default:                 nxt_st = pfcr_pkg::pfcr_st_por;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff  <= pfcr_pkg::pfcr_st_por;
            cnt_ff <= '0;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= (nxt_st != st_ff) ? 32'd0 : cnt_ff + 32'd1;
        end
    end

    // ----------------------------------------------------------------
    // Flash pins
    // ----------------------------------------------------------------
    assign config_clk_out     = clk_ff;
    assign flash_hard_reset_n = !in_por;
    assign flash_chip_en_n    = !(in_wr || clk_run);
    assign flash_addr_valid_n = !(we_act || in_baddr);
    assign flash_write_en_n   = !we_act;
    assign flash_out_en_n     = !in_bdata;
    // Only 24 word-address lines; larger parts take their upper lines externally
    assign flash_word_addr    = in_wr ? RCR_ADDR : addr_ff;
    assign flash_data_oe      = in_wr;
    assign flash_data_o       = in_wrset ? `PFCR_CMD_CFG_SETUP : `PFCR_CMD_CFG_CONFIRM;

    // ----------------------------------------------------------------
    // Status, done and user I/O
    // ----------------------------------------------------------------
    assign config_status_n_o  = 1'b0;
    assign config_status_n_oe = in_por;
    assign config_complete_o  = 1'b0;
    assign config_complete_oe = !(in_dwait || in_init || in_user);
    assign user_io_oe         = in_user;
    assign weak_pullup_en     = !in_por && !in_user;
    assign user_mode          = in_user;

endmodule : pfcr_top

//--- pfcr_regs.svh
// Constants of the parallel flash configuration reader: clocks, delays,
// flash commands and strap codes.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef PFCR_REGS_SVH
`define PFCR_REGS_SVH

// ----------------------------------------------------------------
// Clocks
// ----------------------------------------------------------------
`define PFCR_SYS_HZ          50000000
`define PFCR_CFG_MAX_HZ      40000000
// Half period of the configuration clock, rounded up so it never exceeds the cap
`define PFCR_CFG_HALF_CYC    ((`PFCR_SYS_HZ + 2 * `PFCR_CFG_MAX_HZ - 1) / (2 * `PFCR_CFG_MAX_HZ))

// ----------------------------------------------------------------
// Power-on delays, least times, rounded up past the bound
// ----------------------------------------------------------------
`define PFCR_POR_FAST_MIN_US 3000
`define PFCR_POR_STD_MIN_US  50000
`define PFCR_POR_FAST_CYC    (`PFCR_POR_FAST_MIN_US * (`PFCR_SYS_HZ / 1000000) + 1)
`define PFCR_POR_STD_CYC     (`PFCR_POR_STD_MIN_US * (`PFCR_SYS_HZ / 1000000) + 1)
`define PFCR_INIT_CYC        3185

// ----------------------------------------------------------------
// Asynchronous write timing and read-configuration commands
// ----------------------------------------------------------------
`define PFCR_WR_PHASE_CYC    4
`define PFCR_CMD_CFG_SETUP   16'h0060
`define PFCR_CMD_CFG_CONFIRM 16'h0003

// ----------------------------------------------------------------
// Scheme select straps giving the fast power-on delay
// ----------------------------------------------------------------
`define PFCR_SCHEME_SELECT_PINS_FAST_A     4'h5
`define PFCR_SCHEME_SELECT_PINS_FAST_B     4'h6

`endif

//--- pfcr_pkg.sv
// Types of the parallel flash configuration reader.
// Assumes nothing of its surroundings.
package pfcr_pkg;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [9:0] {
        pfcr_st_por   = 10'h001,
        pfcr_st_frst  = 10'h002,
        pfcr_st_wrset = 10'h004,
        pfcr_st_wrcnf = 10'h008,
        pfcr_st_baddr = 10'h010,
        pfcr_st_bdata = 10'h020,
        pfcr_st_drain = 10'h040,
        pfcr_st_dwait = 10'h080,
        pfcr_st_init  = 10'h100,
        pfcr_st_user  = 10'h200
    } pfcr_state_t;

endpackage : pfcr_pkg

//--- pfcr_top_assertions.sv
// Checker of the configuration reader's pin behaviour.
// Bound to pfcr_top; sees its ports only.
`timescale 1ns/1ps
module pfcr_top_assertions #(
    parameter int          ADDR_W     = 24,
    parameter int unsigned INIT_CYC   = 3185,
    parameter logic [23:0] START_ADDR = 24'h000000
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst,
    // Status and user pins
    input wire logic              config_status_n_oe,
    input wire logic              config_complete_i,
    input wire logic              user_io_oe,
    input wire logic              user_mode,
    // Flash pins
    input wire logic              config_clk_out,
    input wire logic              flash_hard_reset_n,
    input wire logic              flash_chip_en_n,
    input wire logic              flash_out_en_n,
    input wire logic              flash_addr_valid_n,
    input wire logic              flash_write_en_n,
    input wire logic [ADDR_W-1:0] flash_word_addr,
    input wire logic              flash_data_oe
);
    // Cycles the done pin has stood high
    logic [31:0] done_cnt_ff;
    logic [31:0] nxt_done_cnt;
    assign nxt_done_cnt = config_complete_i ? done_cnt_ff + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk) done_cnt_ff <= rst ? 32'h0 : nxt_done_cnt;

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_clk_cap; config_clk_out |=> !config_clk_out; endproperty
    a_clk_cap: assert property (p_clk_cap)
        else $error("config clock high two cycles");
    property p_bus_turn; !flash_out_en_n |-> !flash_data_oe && !flash_chip_en_n; endproperty
    a_bus_turn: assert property (p_bus_turn)
        else $error("bus driven while flash reads");
    property p_write;
        !flash_write_en_n |-> flash_data_oe && !flash_chip_en_n && flash_out_en_n && !config_clk_out;
    endproperty
    a_write: assert property (p_write)
        else $error("write strobe without async write");
    property p_por_pins; !flash_hard_reset_n |-> config_status_n_oe && !user_io_oe; endproperty
    a_por_pins: assert property (p_por_pins)
        else $error("pins wrong in power-on reset");
    property p_start_read; $fell(config_status_n_oe) |-> ##[1:40] !flash_chip_en_n; endproperty
    a_start_read: assert property (p_start_read)
        else $error("no flash access after status release");
    property p_init; $rose(user_mode) |-> done_cnt_ff >= INIT_CYC && user_io_oe; endproperty
    a_init: assert property (p_init)
        else $error("user mode too early");
    property p_addr_step;
        !flash_out_en_n && $changed(flash_word_addr) |-> flash_word_addr == $past(flash_word_addr) + 1;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("burst address skipped");
    property p_addr_load;
        !flash_addr_valid_n && flash_write_en_n |-> flash_word_addr == START_ADDR && !flash_chip_en_n;
    endproperty
    a_addr_load: assert property (p_addr_load)
        else $error("burst start address wrong");
endmodule : pfcr_top_assertions

bind pfcr_top pfcr_top_assertions #(.ADDR_W(ADDR_W), .INIT_CYC(INIT_CYC), .START_ADDR(START_ADDR))
    pfcr_top_assertions_i (.sys_clk(sys_clk), .rst(rst), .config_status_n_oe(config_status_n_oe),
    .config_complete_i(config_complete_i), .user_io_oe(user_io_oe), .user_mode(user_mode),
    .config_clk_out(config_clk_out), .flash_hard_reset_n(flash_hard_reset_n),
    .flash_chip_en_n(flash_chip_en_n), .flash_out_en_n(flash_out_en_n),
    .flash_addr_valid_n(flash_addr_valid_n), .flash_write_en_n(flash_write_en_n),
    .flash_word_addr(flash_word_addr), .flash_data_oe(flash_data_oe));

//--- pfcr_flash_model.sv
// Burst flash model facing the configuration reader.
// Assumes the reader's strobes; data bus resolved by the bench.
`timescale 1ns/1ps
module pfcr_flash_model #(
    parameter int          STALL_EVERY = 3,
    parameter logic [23:0] RCR_ADDR    = 24'h000000
) (
    // Controls from the reader
    input wire logic        clk,
    input wire logic        hard_reset_n,
    input wire logic        chip_en_n,
    input wire logic        out_en_n,
    input wire logic        addr_valid_n,
    input wire logic        write_en_n,
    input wire logic [23:0] addr,
    // Data bus and wait
    input wire logic [15:0] bus,
    output logic [15:0]     data,
    output logic            mem_wait
);
    logic [15:0] data_q = 16'h0000;
    logic        wait_q = 1'b1;
    logic [23:0] ptr_q;
    logic [23:0] base_q;
    logic        setup_q;
    logic        sync_q;
    int          reqs   = 0;
    int          n_sent = 0;
    // Released lines show the inverse of the last value
    assign data     = out_en_n ? ~data_q : data_q;
    assign mem_wait = out_en_n ? ~wait_q : wait_q;
    always @(posedge write_en_n or negedge hard_reset_n) begin
        if (!hard_reset_n) begin
            setup_q <= 1'b0;
            sync_q  <= 1'b0;
        end else if (!chip_en_n && addr == RCR_ADDR) begin
            setup_q <= bus == 16'h0060;
            sync_q  <= sync_q || (setup_q && bus == 16'h0003);
        end
    end
    // Stalls every few words; never valid before burst mode is set
    always @(posedge clk) begin
        if (!addr_valid_n && !chip_en_n) begin
            ptr_q  <= addr;
            base_q <= addr;
        end else if (!out_en_n && !chip_en_n) begin
            reqs   <= reqs + 1;
            wait_q <= !sync_q || reqs % STALL_EVERY == STALL_EVERY - 1;
            if (sync_q && reqs % STALL_EVERY != STALL_EVERY - 1) begin
                data_q <= ptr_q[15:0] ^ 16'hC35A;
                ptr_q  <= ptr_q + 24'h1;
                n_sent <= n_sent + 1;
            end
        end
    end
endmodule : pfcr_flash_model

//--- tb.sv
// Bench of the configuration reader with a burst flash model.
// Assumes the design, checker and flash model compiled before it.
`timescale 1ns/1ps
module tb;
    localparam int          WORDS = 8;
    localparam int          INIT  = 20;
    localparam logic [23:0] START = 24'h001230;
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [3:0]  straps    = 4'h5;
    logic        done_hold = 1'b0;
    logic        ready     = 1'b0;
    logic        cc_o, cc_oe, st_o, st_oe, uio_oe, pu_en, umode, clk_o, hrst_n;
    logic        ce_n, oe_n, avd_n, we_n, dat_oe, m_wait, vld, cc_i;
    logic [23:0] addr;
    logic [15:0] d_o, m_data, bus, wdata;
    int          fails    = 0;
    int          compares = 0;
    // Open-drain done pin with pull-up, optionally held low
    assign cc_i = cc_oe ? cc_o : !done_hold;
    assign bus  = dat_oe ? d_o : m_data;
    always #10 sys_clk = ~sys_clk;

    pfcr_top #(.POR_FAST_CYC(50), .POR_STD_CYC(80), .INIT_CYC(INIT), .BITSTREAM_WORDS(WORDS),
        .START_ADDR(START)) pfcr_top_i (.sys_clk(sys_clk), .rst(rst), .scheme_select_pins(straps),
        .config_status_n_o(st_o), .config_status_n_oe(st_oe), .config_complete_i(cc_i),
        .config_complete_o(cc_o), .config_complete_oe(cc_oe), .user_io_oe(uio_oe),
        .weak_pullup_en(pu_en), .user_mode(umode), .config_clk_out(clk_o),
        .flash_hard_reset_n(hrst_n), .flash_chip_en_n(ce_n), .flash_out_en_n(oe_n),
        .flash_addr_valid_n(avd_n), .flash_write_en_n(we_n), .flash_word_addr(addr),
        .flash_data_i(bus), .flash_data_o(d_o), .flash_data_oe(dat_oe), .flash_wait(m_wait),
        .cfg_word_data(wdata), .cfg_word_valid(vld), .cfg_word_ready(ready));
    pfcr_flash_model pfcr_flash_model_i (.clk(clk_o), .hard_reset_n(hrst_n), .chip_en_n(ce_n),
        .out_en_n(oe_n), .addr_valid_n(avd_n), .write_en_n(we_n), .addr(addr), .bus(bus),
        .data(m_data), .mem_wait(m_wait));

    task automatic report_and_stop;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            fails++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            chk(1'b0, "wait ran out");
            report_and_stop;
        end
    endtask : bound
    task automatic do_reset(input logic [3:0] code);
        rst    = 1'b1;
        straps = code;
        cyc(4);
        rst    = 1'b0;
    endtask : do_reset

    // Power-on delay for both fast strap codes and three standard ones
    task automatic t_por;
        logic [3:0] codes [5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hB};
        int         n;
        int         lim;
        for (int k = 0; k < 5; k++) begin
            lim = k < 2 ? 50 : 80;
            do_reset(codes[k]);
            chk(hrst_n === 1'b0 && st_oe === 1'b1 && uio_oe === 1'b0, "reset pins");
            chk(st_o === 1'b0 && cc_oe === 1'b1 && cc_o === 1'b0, "status and done low");
            for (n = 0; n < 300 && hrst_n !== 1'b1; n++) cyc(1);
            bound(n, 300);
            chk(n >= lim - 1 && n <= lim + 2, "power-on delay length");
        end
    endtask : t_por

    // Full load: buffer fills with sink stalled, then drain, done and init
    task automatic t_stream;
        int n;
        int i;
        do_reset(4'h6);
        done_hold = 1'b1;
        for (n = 0; n < 400 && ce_n !== 1'b0; n++) cyc(1);
        bound(n, 400);
        chk(st_oe === 1'b0 && pu_en === 1'b1 && uio_oe === 1'b0, "pins after reset");
        cyc(300);
        chk(pfcr_flash_model_i.sync_q === 1'b1, "burst mode not set");
        chk(pfcr_flash_model_i.base_q === START, "burst start address");
        chk(pfcr_flash_model_i.n_sent == 4, "fetch past full buffer");
        ready = 1'b1;
        i = 0;
        for (n = 0; n < 1000 && i < WORDS; n++) begin
            if (vld === 1'b1) begin
                chk(wdata === ((START[15:0] + i[15:0]) ^ 16'hC35A), "word order");
                i++;
            end
            cyc(1);
        end
        bound(n, 1000);
        for (n = 0; n < 200 && cc_oe !== 1'b0; n++) cyc(1);
        bound(n, 200);
        cyc(30);
        chk(umode === 1'b0 && ce_n === 1'b1, "init before done high");
        done_hold = 1'b0;
        for (n = 0; n < 1000 && umode !== 1'b1; n++) cyc(1);
        bound(n, 1000);
        chk(n >= INIT && n <= INIT + 4, "init length");
        chk(uio_oe === 1'b1 && pu_en === 1'b0, "user mode pins");
    endtask : t_stream

    initial begin
        t_por;
        t_stream;
        report_and_stop;
    end
endmodule : tb
